// file: inc/pmc_pkg.sv
// constants and carrier types for the power mode clock manager
package pmc_pkg;
  localparam int PMC_DIV_W = 8;
  localparam int PMC_NUM_UNITS = 8;
  localparam int PMC_NUM_WAKE = 8;
  localparam logic [7:0] PMC_DIV_RST = 8'h00;
  localparam logic [7:0] PMC_GATE_RST = 8'hff;
  localparam logic [7:0] PMC_WAKE_EN_RST = 8'h00;
  // port pins rest high on their pull-ups; edge history starts there
  localparam logic [7:0] PMC_PIN_IDLE = 8'hff;

  typedef enum logic [1:0] {
    PMC_CMD_NONE,
    PMC_CMD_IDLE,
    PMC_CMD_STOP
  } pmc_cmd_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic phy_rx_clk_en;
    logic phy_tx_clk_en;
    logic osc_run;
  } pmc_domain_t;
endpackage

// file: hw/pmc_top.sv
// power mode clock manager: divider, unit gating and normal/idle/stop control
`timescale 1ns/1ps

// How it works
// - firmware divide value n gives one enable pulse every n+1 clocks, up to 256
// - each unit clock enable follows its firmware gate bit in normal and idle mode
// - divider and gate values may change at any time in normal mode
// - idle stops the cpu clock while the phy receive clock keeps running
// - oscillator and phy receive clock never stop while in idle
// - a sync detect during idle returns the block to normal mode
// - stop turns off every clock enable and the oscillator
// - only an enabled external interrupt pin leaves stop mode
// - stop is entered only from the firmware stop command
// - port pins selected by a wake mask act as interrupts and stop wake-ups
module pmc_top
  import pmc_pkg::*;
(
  input wire logic CLK_IN, // system clock, 200 MHz
  input wire logic RST_B_IN, // synchronous reset, active low
  input wire logic [PMC_DIV_W-1:0] DIV_SEL_IN, // divide ratio minus one
  input wire logic DIV_LOAD_IN, // pulse: take DIV_SEL_IN
  input wire logic [PMC_NUM_UNITS-1:0] GATE_IN, // per-unit clock enable request
  input wire logic GATE_LOAD_IN, // pulse: take GATE_IN
  input wire logic [1:0] CMD_IN, // mode command (pmc_cmd_t)
  input wire logic CMD_VALID_IN, // pulse: command strobe from firmware
  input wire logic SYNC_DET_IN, // phy receive path saw packet sync
  input wire logic [PMC_NUM_WAKE-1:0] PORT_PIN_IN, // port pins, active high interrupt
  input wire logic [PMC_NUM_WAKE-1:0] WAKE_EN_IN, // pins allowed as interrupt/wake
  output logic DIV_TICK_OUT, // one-cycle divided clock enable
  output logic [PMC_NUM_UNITS-1:0] UNIT_CLK_EN_OUT, // gated unit clock enables
  output logic CPU_CLK_EN_OUT, // cpu core clock enable
  output logic PHY_RX_CLK_EN_OUT, // phy receive clock enable
  output logic PHY_TX_CLK_EN_OUT, // phy transmit clock enable
  output logic OSC_RUN_OUT, // oscillator and pll run
  output logic EXT_IRQ_OUT, // pulse: enabled pin interrupt
  output logic [1:0] MODE_OUT // 0 normal, 1 idle, 2 stop
);

  typedef enum logic [1:0] {ST_NORMAL, ST_IDLE, ST_STOP} pmc_state_t;

  pmc_state_t state_reg, state_next;
  logic [PMC_DIV_W-1:0] div_sel_reg, div_sel_next;
  logic [PMC_DIV_W-1:0] div_cnt_reg, div_cnt_next;
  logic [PMC_NUM_UNITS-1:0] gate_reg, gate_next;
  logic [PMC_NUM_WAKE-1:0] pin_prev_reg;
  logic tick_reg, tick_next;
  logic irq_reg, irq_next;
  logic wake_hit;
  pmc_domain_t dom_reg, dom_next;
  logic [PMC_NUM_UNITS-1:0] unit_en_reg, unit_en_next;

  // ----------------------------------------
  // divider and gating settings
  // ----------------------------------------
  always_comb
  begin
    div_sel_next = div_sel_reg;
    gate_next = gate_reg;
    if (DIV_LOAD_IN && state_reg == ST_NORMAL)
    begin
      div_sel_next = DIV_SEL_IN;
    end
    if (GATE_LOAD_IN && state_reg == ST_NORMAL)
    begin
      gate_next = GATE_IN;
    end
    // settings registers are never cleared by mode changes
  end

  // divider counts on the system clock; halted in stop, kept value on return
  always_comb
  begin
    div_cnt_next = div_cnt_reg;
    tick_next = 1'b0;
    if (state_reg != ST_STOP)
    begin
      if (div_cnt_reg >= div_sel_reg)
      begin
        div_cnt_next = 8'h00;
        tick_next = 1'b1;
      end
      else
      begin
        div_cnt_next = div_cnt_reg + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // mode control
  // ----------------------------------------
  // pins are taken as synchronous; rising edge on an enabled pin is the event
  assign wake_hit = |(PORT_PIN_IN & ~pin_prev_reg & WAKE_EN_IN);

  always_comb
  begin
    state_next = state_reg;
    irq_next = wake_hit;
    case (state_reg)
      ST_NORMAL:
      begin
        if (CMD_VALID_IN && CMD_IN == PMC_CMD_STOP)
        begin
          state_next = ST_STOP;
        end
        else if (CMD_VALID_IN && CMD_IN == PMC_CMD_IDLE)
        begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE:
      begin
        // sync or pin interrupt wakes; stop is never reached from here, not even by a firmware stop command
        if (SYNC_DET_IN || wake_hit)
        begin
          state_next = ST_NORMAL;
        end
      end
      ST_STOP:
      begin
        if (wake_hit)
        begin
          state_next = ST_NORMAL;
        end
      end
      default:
      begin
        state_next = ST_NORMAL;
      end
    endcase
  end

  // ----------------------------------------
  // clock enables, decided from the next state so they move with MODE_OUT
  // ----------------------------------------
  always_comb
  begin
    dom_next.osc_run = 1'b1;
    dom_next.cpu_clk_en = 1'b1;
    dom_next.phy_rx_clk_en = 1'b1;
    dom_next.phy_tx_clk_en = 1'b1;
    unit_en_next = gate_next;
    case (state_next)
      ST_IDLE:
      begin
        dom_next.cpu_clk_en = 1'b0;
        dom_next.phy_tx_clk_en = 1'b0;
        dom_next.phy_rx_clk_en = 1'b1;
        dom_next.osc_run = 1'b1;
      end
      ST_STOP:
      begin
        dom_next.osc_run = 1'b0;
        dom_next.cpu_clk_en = 1'b0;
        dom_next.phy_rx_clk_en = 1'b0;
        dom_next.phy_tx_clk_en = 1'b0;
        unit_en_next = '0;
      end
      default:
      begin
        unit_en_next = gate_next;
      end
    endcase
  end

  always_ff @(posedge CLK_IN)
  begin
    if (!RST_B_IN)
    begin
      state_reg <= ST_NORMAL;
      div_sel_reg <= PMC_DIV_RST;
      div_cnt_reg <= 8'h00;
      gate_reg <= PMC_GATE_RST;
      pin_prev_reg <= PMC_PIN_IDLE; // a pin resting high is no edge after reset
      tick_reg <= 1'b0;
      irq_reg <= 1'b0;
      dom_reg <= '{cpu_clk_en: 1'b1, phy_rx_clk_en: 1'b1, phy_tx_clk_en: 1'b1, osc_run: 1'b1};
      unit_en_reg <= PMC_GATE_RST;
    end
    else
    begin
      state_reg <= state_next;
      div_sel_reg <= div_sel_next;
      div_cnt_reg <= div_cnt_next;
      gate_reg <= gate_next;
      pin_prev_reg <= PORT_PIN_IN;
      tick_reg <= tick_next;
      irq_reg <= irq_next;
      dom_reg <= dom_next;
      unit_en_reg <= unit_en_next;
    end
  end

  assign DIV_TICK_OUT = tick_reg;
  assign UNIT_CLK_EN_OUT = unit_en_reg;
  assign CPU_CLK_EN_OUT = dom_reg.cpu_clk_en;
  assign PHY_RX_CLK_EN_OUT = dom_reg.phy_rx_clk_en;
  assign PHY_TX_CLK_EN_OUT = dom_reg.phy_tx_clk_en;
  assign OSC_RUN_OUT = dom_reg.osc_run;
  assign EXT_IRQ_OUT = irq_reg;
  assign MODE_OUT = state_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);

  a_div_period: assert property ((DIV_TICK_OUT && div_sel_reg == 8'h01
    && state_reg == ST_NORMAL) ##1 (div_sel_reg == 8'h01 && state_reg == ST_NORMAL)
    |-> !DIV_TICK_OUT ##1 DIV_TICK_OUT)
    else $error("divider period wrong");
  a_gate_follow: assert property (state_reg == ST_NORMAL && !GATE_LOAD_IN
    && state_next == ST_NORMAL |=> UNIT_CLK_EN_OUT == gate_reg)
    else $error("unit enable does not follow gate");
  a_div_load: assert property (DIV_LOAD_IN && state_reg == ST_NORMAL
    |=> div_sel_reg == $past(DIV_SEL_IN))
    else $error("divider load lost");
  a_idle_cpu_off: assert property (MODE_OUT == 2'd1 |-> !CPU_CLK_EN_OUT && PHY_RX_CLK_EN_OUT)
    else $error("idle clocks wrong");
  a_idle_clock_on: assert property (MODE_OUT == 2'd1 |-> OSC_RUN_OUT)
    else $error("idle with no clock");
  a_sync_wake: assert property (state_reg == ST_IDLE && SYNC_DET_IN
    |=> MODE_OUT == 2'd0 && CPU_CLK_EN_OUT)
    else $error("sync did not wake");
  a_stop_all_off: assert property (MODE_OUT == 2'd2 |-> !OSC_RUN_OUT && !CPU_CLK_EN_OUT
    && !PHY_RX_CLK_EN_OUT && UNIT_CLK_EN_OUT == 8'h00)
    else $error("stop left a clock on");
  a_stop_exit: assert property (state_reg == ST_STOP && !wake_hit |=> state_reg == ST_STOP)
    else $error("stop left without interrupt");
  a_stop_cmd: assert property (state_reg != ST_STOP
    && !(CMD_VALID_IN && CMD_IN == PMC_CMD_STOP) |=> state_reg != ST_STOP)
    else $error("stop without command");
  a_pin_irq: assert property (wake_hit |=> EXT_IRQ_OUT)
    else $error("pin interrupt missed");
  a_keep_gate: assert property (state_reg != ST_NORMAL |=> $stable(gate_reg)
    && $stable(div_sel_reg))
    else $error("settings lost in low power");

  c_idle_wake: cover property (state_reg == ST_IDLE ##1 state_reg == ST_NORMAL);
  c_stop_wake: cover property (state_reg == ST_STOP ##1 state_reg == ST_NORMAL);
  c_div_max: cover property (div_sel_reg == 8'hff && DIV_TICK_OUT);
endmodule

// file: test/test_pmc_top.sv
// self-checking bench for the power mode clock manager
`timescale 1ns/1ps
module test_pmc_top
  import pmc_pkg::*;
;
  logic CLK_IN = 1'b0;
  logic RST_B_IN = 1'b0;
  logic [7:0] DIV_SEL_IN = 8'h00;
  logic DIV_LOAD_IN = 1'b0;
  logic [7:0] GATE_IN = 8'h00;
  logic GATE_LOAD_IN = 1'b0;
  logic [1:0] CMD_IN = 2'h0;
  logic CMD_VALID_IN = 1'b0;
  logic SYNC_DET_IN = 1'b0;
  logic [7:0] PORT_PIN_IN = 8'h00;
  logic [7:0] WAKE_EN_IN = 8'h00;
  logic DIV_TICK_OUT, CPU_CLK_EN_OUT, PHY_RX_CLK_EN_OUT, PHY_TX_CLK_EN_OUT;
  logic OSC_RUN_OUT, EXT_IRQ_OUT;
  logic [7:0] UNIT_CLK_EN_OUT;
  logic [1:0] MODE_OUT;
  int errors = 0;
  int total_checks = 0;

  pmc_top i_dut (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .DIV_SEL_IN(DIV_SEL_IN),
    .DIV_LOAD_IN(DIV_LOAD_IN), .GATE_IN(GATE_IN), .GATE_LOAD_IN(GATE_LOAD_IN),
    .CMD_IN(CMD_IN), .CMD_VALID_IN(CMD_VALID_IN), .SYNC_DET_IN(SYNC_DET_IN),
    .PORT_PIN_IN(PORT_PIN_IN), .WAKE_EN_IN(WAKE_EN_IN), .DIV_TICK_OUT(DIV_TICK_OUT),
    .UNIT_CLK_EN_OUT(UNIT_CLK_EN_OUT), .CPU_CLK_EN_OUT(CPU_CLK_EN_OUT),
    .PHY_RX_CLK_EN_OUT(PHY_RX_CLK_EN_OUT), .PHY_TX_CLK_EN_OUT(PHY_TX_CLK_EN_OUT),
    .OSC_RUN_OUT(OSC_RUN_OUT), .EXT_IRQ_OUT(EXT_IRQ_OUT), .MODE_OUT(MODE_OUT));

  initial
  begin
    forever #2.5 CLK_IN = ~CLK_IN;
  end

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  // inputs move 1 ns after the edge so the design samples settled values
  task step(input int n);
    repeat (n) begin @(posedge CLK_IN); #1; end
  endtask

  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task chk_st(input logic [1:0] m, input logic [3:0] en, input logic [7:0] u);
    chk("mode", {6'h00, m}, {6'h00, MODE_OUT});
    chk("enables", {4'h0, en},
      {4'h0, CPU_CLK_EN_OUT, PHY_RX_CLK_EN_OUT, PHY_TX_CLK_EN_OUT, OSC_RUN_OUT});
    chk("unit", u, UNIT_CLK_EN_OUT);
  endtask

  task cmd(input logic [1:0] c);
    CMD_IN = c; CMD_VALID_IN = 1'b1; step(1); CMD_VALID_IN = 1'b0;
  endtask

  task load(input logic [7:0] d, input logic [7:0] g, input logic ld, input logic lg);
    DIV_SEL_IN = d; GATE_IN = g; DIV_LOAD_IN = ld; GATE_LOAD_IN = lg;
    step(1); DIV_LOAD_IN = 1'b0; GATE_LOAD_IN = 1'b0;
  endtask

  task sync_pulse();
    SYNC_DET_IN = 1'b1; step(1); SYNC_DET_IN = 1'b0;
  endtask

  // window lengths are whole periods, so the count ignores the phase
  task ticks(input int n, input logic [7:0] exp);
    int k;
    k = 0;
    repeat (n) begin step(1); if (DIV_TICK_OUT === 1'b1) k++; end
    chk("ticks", exp, 8'(k));
  endtask

  task tally_and_finish();
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    step(20); RST_B_IN = 1'b1; step(2);
    chk_st(2'h0, 4'hf, 8'hff);
    ticks(8, 8'h08);
    load(8'hff, 8'h00, 1'b1, 1'b0); step(256);
    ticks(512, 8'h02);
    load(8'h03, 8'h0f, 1'b1, 1'b1); step(8);
    ticks(16, 8'h04);
    chk("unit", 8'h0f, UNIT_CLK_EN_OUT);
    sync_pulse();
    chk("mode", 8'h00, {6'h00, MODE_OUT});
    cmd(PMC_CMD_IDLE);
    chk_st(2'h1, 4'b0101, 8'h0f);
    load(8'h00, 8'hff, 1'b1, 1'b1);
    chk("unit", 8'h0f, UNIT_CLK_EN_OUT);
    ticks(16, 8'h04);
    cmd(PMC_CMD_STOP);
    chk("mode", 8'h01, {6'h00, MODE_OUT});
    sync_pulse();
    chk_st(2'h0, 4'hf, 8'h0f);
    cmd(2'h3);
    chk("mode", 8'h00, {6'h00, MODE_OUT});
    cmd(PMC_CMD_STOP);
    chk_st(2'h2, 4'h0, 8'h00);
    ticks(16, 8'h00);
    sync_pulse();
    chk("mode", 8'h02, {6'h00, MODE_OUT});
    PORT_PIN_IN = 8'h02; step(1);
    chk("irq", 8'h00, {7'h00, EXT_IRQ_OUT});
    chk("mode", 8'h02, {6'h00, MODE_OUT});
    WAKE_EN_IN = 8'h08; PORT_PIN_IN = 8'h0a; step(1);
    chk_st(2'h0, 4'hf, 8'h0f);
    chk("irq", 8'h01, {7'h00, EXT_IRQ_OUT});
    step(1);
    chk("irq", 8'h00, {7'h00, EXT_IRQ_OUT});
    step(4);
    ticks(16, 8'h04);
    load(8'h01, 8'h0f, 1'b1, 1'b0);
    step(2);
    ticks(16, 8'h08);
    // mid-run reset out of stop with pins resting high: no false wake edge
    cmd(PMC_CMD_STOP);
    RST_B_IN = 1'b0;
    PORT_PIN_IN = 8'hff;
    WAKE_EN_IN = 8'hff;
    step(8);
    RST_B_IN = 1'b1;
    step(1);
    chk("irq", 8'h00, {7'h00, EXT_IRQ_OUT});
    chk_st(2'h0, 4'hf, 8'hff);
    step(1);
    chk("irq", 8'h00, {7'h00, EXT_IRQ_OUT});
    tally_and_finish();
  end

  // run needs about 4.6 us; a hang is cut off well past that
  initial
  begin
    #20000;
    errors++;
    tally_and_finish();
  end
endmodule
